// file: rtl/tsh_sync.sv
// Transmit synchronization handshake for a multi-system echo sounder.
`timescale 1ns/10ps

// Behaviour
// - Three modes; free mode ignores sync inputs.
// - Reset selects master mode by default.
// - Slave starts on clear-to-send rising edge.
// - Request-to-send rises lead time before transmit.
// - Request-to-send held until sampling done.
// - Master drives request; clear-to-send is acknowledge.
// - Aux trigger permits next slave transmission.
// - Aux triggers detect high-to-low on negative, low-to-high on positive.
// - Two aux triggers, positive and negative.
// - Master sequences units; slave triggers each.
// - Event and log inputs are ignored.
module tsh_sync #(
   parameter int LEAD_CYC = tsh_pkg::TSH_LEAD_CYC
)(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Configuration.
   input wire tsh_pkg::tsh_mode_t mode,
   input wire logic mode_valid,
   // External pins.
   input wire tsh_pkg::tsh_pins_t pins,
   input wire logic event_in,
   input wire logic log_in,
   // Local transmit control.
   input wire logic sched_tick,
   input wire logic sample_done,
   // Outputs.
   output logic rts,
   output logic [tsh_pkg::TSH_UNITS-1:0] tx_start,
   output logic active,
   output logic ack_seen
);

   // State register, next state and registered mode.
   tsh_pkg::tsh_state_reg_t s_r;
   tsh_pkg::tsh_state_reg_t s_nxt;
   tsh_pkg::tsh_mode_t mode_r;
   logic cts_rise;
   logic trig_fall;
   logic go;
   // Counter width and unit count, and the lead reload value cut to the counter width on purpose.
   localparam int CW = tsh_pkg::TSH_CW;
   localparam int UNITS = tsh_pkg::TSH_UNITS;
   localparam logic [CW-1:0] LEAD_LOAD = CW'(LEAD_CYC - 1);

   // Mode register; master until configured.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mode_r <= tsh_pkg::TSH_MODE_MASTER;
      end
      else if (mode_valid)
      begin
         mode_r <= mode;
      end
   end

   // Edge detection on the agreeing second and third stages only.
   always_comb
   begin
      cts_rise = s_r.cts_s[1] & ~s_r.cts_s[2];
      trig_fall = (~s_r.tneg_s[1] & s_r.tneg_s[2]) | (s_r.tpos_s[1] & ~s_r.tpos_s[2]);
   end

   // Start condition per mode; event and log pins never enter here.
   always_comb
   begin
      unique case (mode_r)
         tsh_pkg::TSH_MODE_SLAVE: go = cts_rise | trig_fall;
         tsh_pkg::TSH_MODE_FREE: go = sched_tick;
         tsh_pkg::TSH_MODE_MASTER: go = sched_tick;
         default: go = 1'b0;
      endcase
   end

   // Next state computation.
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.cts_s = {s_r.cts_s[1:0], pins.cts};
      s_nxt.tpos_s = {s_r.tpos_s[1:0], pins.trig_pos};
      s_nxt.tneg_s = {s_r.tneg_s[1:0], pins.trig_neg};
      if (mode_r == tsh_pkg::TSH_MODE_MASTER && s_r.rts && cts_rise)
      begin
         s_nxt.ack = 1'b1;
      end
      unique case (s_r.st)
         tsh_pkg::TSH_IDLE:
         begin
            if (go)
            begin
               s_nxt.st = tsh_pkg::TSH_LEAD;
               s_nxt.rts = 1'b1;
               s_nxt.ack = 1'b0;
               s_nxt.cnt = LEAD_LOAD;
            end
         end
         tsh_pkg::TSH_LEAD:
         begin
            if (s_r.cnt == '0)
            begin
               s_nxt.st = tsh_pkg::TSH_XMIT;
            end
            else
            begin
               s_nxt.cnt = s_r.cnt - 1'b1;
            end
         end
         tsh_pkg::TSH_XMIT:
         begin
            if (mode_r == tsh_pkg::TSH_MODE_MASTER)
            begin
               s_nxt.unit = {s_r.unit[tsh_pkg::TSH_UNITS-2:0],
                  s_r.unit[tsh_pkg::TSH_UNITS-1]};
            end
            s_nxt.st = tsh_pkg::TSH_SAMPLE;
         end
         tsh_pkg::TSH_SAMPLE:
         begin
            if (sample_done)
            begin
               s_nxt.st = tsh_pkg::TSH_IDLE;
               s_nxt.rts = 1'b0;
            end
         end
      endcase
   end

   // State register.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.st <= tsh_pkg::TSH_IDLE;
         s_r.unit <= UNITS'(1);
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs: slave start pulses all units together, master one at a time.
   always_comb
   begin
      rts = s_r.rts;
      active = s_r.rts;
      ack_seen = s_r.ack;
      if (s_r.st != tsh_pkg::TSH_XMIT)
      begin
         tx_start = '0;
      end
      else if (mode_r == tsh_pkg::TSH_MODE_MASTER)
      begin
         tx_start = s_r.unit;
      end
      else
      begin
         tx_start = '1;
      end
   end

   // Request rises with the lead count loaded and no transmit on the next cycle.
   property p_lead;
      @(posedge sys_clk) disable iff (rst)
      $rose(s_r.rts) |-> (s_r.st == tsh_pkg::TSH_LEAD && s_r.cnt == LEAD_LOAD)
         ##1 (tx_start == '0);
   endproperty
   a_lead: assert property (p_lead) else $error("lead start wrong");

   // The last lead cycle is always followed by the transmit pulse.
   property p_lead_end;
      @(posedge sys_clk) disable iff (rst)
      (s_r.st == tsh_pkg::TSH_LEAD && s_r.cnt == '0) |=> (tx_start != '0);
   endproperty
   a_lead_end: assert property (p_lead_end) else $error("lead end missed");

   property p_hold;
      @(posedge sys_clk) disable iff (rst)
      (s_r.st == tsh_pkg::TSH_SAMPLE && !sample_done) |=> rts;
   endproperty
   a_hold: assert property (p_hold) else $error("rts dropped early");

   property p_busy;
      @(posedge sys_clk) disable iff (rst)
      (rts && s_r.st != tsh_pkg::TSH_SAMPLE) |=> rts;
   endproperty
   a_busy: assert property (p_busy) else $error("trigger during busy");

   property p_xmit;
      @(posedge sys_clk) disable iff (rst)
      (tx_start != '0) |-> rts ##1 (tx_start == '0);
   endproperty
   a_xmit: assert property (p_xmit) else $error("start not single");

   property p_slave;
      @(posedge sys_clk) disable iff (rst)
      (mode_r == tsh_pkg::TSH_MODE_SLAVE && s_r.st == tsh_pkg::TSH_IDLE && !cts_rise
         && !trig_fall) |=> !rts;
   endproperty
   a_slave: assert property (p_slave) else $error("slave ran untriggered");

   property p_par;
      @(posedge sys_clk) disable iff (rst)
      (tx_start != '0 && mode_r != tsh_pkg::TSH_MODE_MASTER) |-> tx_start == '1;
   endproperty
   a_par: assert property (p_par) else $error("units not parallel");

   property p_seq;
      @(posedge sys_clk) disable iff (rst)
      (tx_start != '0 && mode_r == tsh_pkg::TSH_MODE_MASTER) |-> $onehot(tx_start);
   endproperty
   a_seq: assert property (p_seq) else $error("master not one unit");

   property p_free;
      @(posedge sys_clk) disable iff (rst)
      (mode_r != tsh_pkg::TSH_MODE_SLAVE && s_r.st == tsh_pkg::TSH_IDLE && !sched_tick)
         |=> !rts;
   endproperty
   a_free: assert property (p_free) else $error("own schedule broken");

endmodule

// file: rtl/tsh_pkg.sv
// Package with the modes, states, timing constants and port structs of the sync block.
package tsh_pkg;

   // Synchronization modes.
   typedef enum logic [1:0] {
      TSH_MODE_FREE,
      TSH_MODE_SLAVE,
      TSH_MODE_MASTER
   } tsh_mode_t;

   // Number of transceiver units sequenced by the block.
   localparam int TSH_UNITS = 2;

   // Lead time of request-to-send before transmit, in microseconds, and clock rate.
   localparam int TSH_LEAD_US = 2500;
   localparam int TSH_CLK_MHZ = 250;
   localparam int TSH_LEAD_CYC = TSH_LEAD_US * TSH_CLK_MHZ;
   localparam int TSH_CW = 20;

   // Synchronizer depth for pin inputs.
   localparam int TSH_SYNC = 3;

   // Sequencer states.
   typedef enum logic [1:0] {
      TSH_IDLE,
      TSH_LEAD,
      TSH_XMIT,
      TSH_SAMPLE
   } tsh_state_t;

   // Raw pins coming from outside the clock domain.
   typedef struct packed {
      logic cts;
      logic trig_pos;
      logic trig_neg;
   } tsh_pins_t;

   // Module state apart from the mode register.
   typedef struct packed {
      logic [TSH_SYNC-1:0] cts_s;
      logic [TSH_SYNC-1:0] tpos_s;
      logic [TSH_SYNC-1:0] tneg_s;
      tsh_state_t st;
      logic [TSH_CW-1:0] cnt;
      logic [TSH_UNITS-1:0] unit;
      logic rts;
      logic ack;
   } tsh_state_reg_t;

endpackage

// file: tb/tsh_slave_model.sv
// Behavioural slave sounder that acknowledges a request after a set delay.
`timescale 1ns/10ps
module tsh_slave_model (
   // Clock.
   input wire logic sys_clk,
   // Acknowledge delay in cycles.
   input wire logic [3:0] dly,
   // Request from the master and acknowledge back.
   input wire logic rts_in,
   output logic ack_out
);
   int n = 0; // Cycles since the request rose.
   always @(posedge sys_clk)
   begin
      n <= rts_in ? n + 1 : 0;
      ack_out <= rts_in && n >= dly;
   end
endmodule

// file: tb/tsh_sync_test.sv
// Self-checking testbench of the transmit synchronization block.
`timescale 1ns/10ps
module tsh_sync_test;
   localparam int LEAD = 8; // Shortened lead time.
   logic sys_clk = 0, rst = 1, mode_valid = 0, event_in = 0, log_in = 0;
   logic sched_tick = 0, sample_done = 0, cts_drv = 0, tpos = 0, tneg = 1;
   logic use_slv = 1, rts, active, ack_seen, slv_ack;
   logic [3:0] dly = 4'h2;
   logic [1:0] tx_start;
   tsh_pkg::tsh_mode_t mode = tsh_pkg::TSH_MODE_FREE;
   tsh_pkg::tsh_pins_t pins;
   int miscompares = 0, cmp_count = 0, seed = 98944, cyc = 0, k, j;
   assign pins = '{cts: use_slv ? slv_ack : cts_drv, trig_pos: tpos, trig_neg: tneg};
   tsh_sync #(.LEAD_CYC(LEAD)) i_tsh_sync (.sys_clk(sys_clk), .rst(rst), .mode(mode),
      .mode_valid(mode_valid), .pins(pins), .event_in(event_in), .log_in(log_in),
      .sched_tick(sched_tick), .sample_done(sample_done), .rts(rts),
      .tx_start(tx_start), .active(active), .ack_seen(ack_seen));
   tsh_slave_model i_tsh_slave_model (.sys_clk(sys_clk), .dly(dly), .rts_in(rts),
      .ack_out(slv_ack));
   // Clock of 4 ns and a cycle ceiling against hangs.
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         miscompares++;
         end_of_test();
      end
   end
   // Compares one value and reports a mismatch.
   task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
      cmp_count++;
      if (exp !== got)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Waits edges, then drives just after; ignored inputs toggle at random.
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
      event_in = $random(seed);
      log_in = $random(seed);
   endtask
   // Loads a synchronization mode.
   task automatic set_mode(input tsh_pkg::tsh_mode_t m);
      mode = m;
      mode_valid = 1;
      tick(1);
      mode_valid = 0;
   endtask
   // Follows one transmit cycle once a start has been given.
   task automatic xfer(input logic [1:0] exp_tx);
      k = 0;
      while (rts !== 1'b1 && k < 12)
      begin
         tick(1);
         k++;
      end
      chk("active", 4'h1, {3'h0, active});
      k = 0;
      while (tx_start === 2'h0 && k < LEAD + 4)
      begin
         sched_tick = (k == 2); // Retrigger during the lead is ignored.
         tick(1);
         k++;
      end
      sched_tick = 0;
      chk("lead", 4'h1, {3'h0, k == LEAD || k == LEAD + 1});
      chk("tx_start", {2'h0, exp_tx}, {2'h0, tx_start});
      tick(3);
      chk("rts_hold", 4'h1, {3'h0, rts});
      sample_done = 1;
      tick(1);
      sample_done = 0;
      chk("rts_fall", 4'h0, {3'h0, rts});
      chk("active_fall", 4'h0, {3'h0, active});
      tick(4);
      chk("no_restart", 4'h0, {3'h0, rts});
   endtask
   // Closing report.
   task automatic end_of_test;
      if (miscompares == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Main sequence: master, free, then slave mode.
   initial
   begin
      tick(20);
      rst = 0;
      tick(2);
      chk("rts_reset", 4'h0, {3'h0, rts});
      for (j = 0; j < 2; j++)
      begin
         dly = j ? 4'h6 : 4'h1;
         sched_tick = 1;
         tick(1);
         sched_tick = 0;
         xfer(j ? 2'h2 : 2'h1);
         chk("ack_seen", 4'h1, {3'h0, ack_seen});
      end
      use_slv = 0;
      set_mode(tsh_pkg::TSH_MODE_FREE);
      for (j = 0; j < 12; j++)
      begin
         {cts_drv, tpos, tneg} = $random(seed);
         tick(1);
         chk("free_pins", 4'h0, {3'h0, rts});
      end
      {cts_drv, tpos, tneg} = 3'h1;
      tick(6); // Random pin edges drain out of the synchronizers first.
      set_mode(tsh_pkg::TSH_MODE_SLAVE);
      tick(2);
      sched_tick = 1;
      tick(1);
      sched_tick = 0;
      tick(4);
      chk("slave_wait", 4'h0, {3'h0, rts});
      for (j = 0; j < 3; j++)
      begin
         tick(1 + $unsigned($random(seed)) % 5);
         if (j == 0) tneg = 0;
         if (j == 1) tpos = 1;
         if (j == 2) cts_drv = 1;
         xfer(2'h3);
         chk("ack_slave", 4'h0, {3'h0, ack_seen});
         {cts_drv, tpos, tneg} = 3'h1;
         tick(6);
      end
      end_of_test();
   end
endmodule
